// ===== hbgc_top.sv
// Purpose: Gate command logic of a full H-bridge: speed, direction, brake,
//          synchronous rectification with dead time, standby and disable.
// Assumes: All inputs are synchronous to sys_clk; analog speed arrives as a
//          ready-made 8-bit code.
// Notes:   Operation
module hbgc_top
  import hbgc_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = IDLE_CYC,
  parameter int unsigned WD_CYCLES   = WD_CYC,
  parameter int unsigned DEAD_CYCLES = DEAD_CYC,
  parameter int unsigned PWM_PERIOD  = PWM_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       speed_input,
  input  wire logic [7:0] speed_level,
  input  wire logic       direction_input,
  input  wire logic       pwm_freq_cap_pin,
  input  wire logic       sleep_req_n,
  input  wire logic       undervoltage_lock,
  input  wire logic       overvoltage_lock,
  input  wire logic       supervisor_reset,
  input  wire logic       watchdog_kick_input,
  input  wire logic       reset_pin_in,
  output logic            reset_pin_out,
  output logic            reset_pin_oe_n,
  output logic            bridge_a_high_gate,
  output logic            bridge_a_low_gate,
  output logic            bridge_b_high_gate,
  output logic            bridge_b_low_gate,
  output logic            standby_active,
  output logic            disable_active
);

  // ****************************************************************
  // Gate pattern decode
  // ****************************************************************

  // Maps a drive mode and the live PWM level to the wanted gate pattern.
  // The low side of the active half-bridge carries the modulation and its
  // own high side takes the complement for free-wheel current.
  function automatic hbgc_bridge_t decode_gates(input hbgc_mode_e mode,
                                                input logic       pwm);
    hbgc_bridge_t g;
    g = '0;
    case (mode)
      HBGC_BRAKE_LO: begin
        g[1] = '{hi: 1'b0, lo: 1'b1};
        g[0] = '{hi: 1'b0, lo: 1'b1};
      end
      HBGC_BRAKE_HI: begin
        g[1] = '{hi: 1'b1, lo: 1'b0};
        g[0] = '{hi: 1'b1, lo: 1'b0};
      end
      HBGC_PWM_FWD: begin
        g[1] = '{hi: 1'b1, lo: 1'b0};
        g[0] = '{hi: ~pwm, lo: pwm};
      end
      HBGC_PWM_BWD: begin
        g[1] = '{hi: ~pwm, lo: pwm};
        g[0] = '{hi: 1'b1, lo: 1'b0};
      end
      HBGC_FULL_FWD: begin
        g[1] = '{hi: 1'b1, lo: 1'b0};
        g[0] = '{hi: 1'b0, lo: 1'b1};
      end
      HBGC_FULL_BWD: begin
        g[1] = '{hi: 1'b0, lo: 1'b1};
        g[0] = '{hi: 1'b1, lo: 1'b0};
      end
      default: begin
        g = '0;
      end
    endcase
    return g;
  endfunction : decode_gates

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0]      idle_cnt_q;
  hbgc_level_e      level_cls;
  hbgc_level_e      level_cls_q;
  logic             idle_zero_q;
  logic             idle_full_q;
  logic [PWM_W-1:0] pwm_cnt_q;
  logic [19:0]      pwm_lhs;
  logic [19:0]      pwm_rhs;
  logic             pwm_int;
  logic             pwm_live;
  hbgc_mode_e       mode;
  hbgc_bridge_t     want;
  logic             force_off;
  logic [31:0]      wd_cnt_q;
  logic             kick_q;
  logic             kick_edge;
  logic             wd_timeout_q;
  logic [RST_W-1:0] rst_cnt_q;
  logic [1:0]       gate_hi_q;
  logic [1:0]       gate_lo_q;

  // ****************************************************************
  // Speed level classification
  // ****************************************************************

  // With the capacitor present the 8-bit level is judged against two
  // thresholds; with the pin grounded the digital input level is used.
  always_comb begin
    if (pwm_freq_cap_pin) begin
      if (speed_level <= LEVEL_ZERO_MAX) begin
        level_cls = HBGC_LVL_ZERO;
      end else if (speed_level >= LEVEL_FULL_MIN) begin
        level_cls = HBGC_LVL_FULL;
      end else begin
        level_cls = HBGC_LVL_MID;
      end
    end else begin
      level_cls = speed_input ? HBGC_LVL_FULL : HBGC_LVL_ZERO;
    end
  end

  // Counts how long the level class has stood still. A digital PWM wave
  // keeps restarting the count, so only a steady level is taken as idle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q  <= 32'h0000_0000;
      level_cls_q <= HBGC_LVL_ZERO;
      idle_zero_q <= 1'b0;
      idle_full_q <= 1'b0;
    end else begin
      level_cls_q <= level_cls;
      if (level_cls != level_cls_q) begin
        idle_cnt_q  <= 32'h0000_0000;
        idle_zero_q <= 1'b0;
        idle_full_q <= 1'b0;
      end else begin
        if (idle_cnt_q <= IDLE_CYCLES) begin
          idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
        end
        // Strictly more than the idle time is needed.
        idle_zero_q <= (idle_cnt_q >= IDLE_CYCLES) && (level_cls_q == HBGC_LVL_ZERO);
        idle_full_q <= (idle_cnt_q >= IDLE_CYCLES) && (level_cls_q == HBGC_LVL_FULL);
      end
    end
  end

  // ****************************************************************
  // Internal PWM generator
  // ****************************************************************

  // Free-running period counter at the PWM rate.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_q <= '0;
    end else if (pwm_cnt_q >= PWM_W'(PWM_PERIOD - 1)) begin
      pwm_cnt_q <= '0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + PWM_W'(1);
    end
  end

  // Duty grows linearly across the band between the two thresholds.
  // Cross-multiplying avoids a divider at the cost of two small products.
  always_comb begin
    pwm_lhs = 20'(pwm_cnt_q) * 20'(LEVEL_FULL_MIN - LEVEL_ZERO_MAX);
    pwm_rhs = 20'(speed_level - LEVEL_ZERO_MAX) * 20'(PWM_PERIOD);
    pwm_int = (speed_level > LEVEL_ZERO_MAX) && (pwm_lhs < pwm_rhs);
  end

  // Source of the modulating wave follows the capacitor pin.
  assign pwm_live = pwm_freq_cap_pin ? pwm_int : speed_input;

  // ****************************************************************
  // Mode selection
  // ****************************************************************

  // Standby and disable come first; then idle levels; otherwise PWM.
  always_comb begin
    if (force_off) begin
      mode = HBGC_OFF;
    end else if (idle_zero_q) begin
      mode = direction_input ? HBGC_BRAKE_HI : HBGC_BRAKE_LO;
    end else if (idle_full_q) begin
      mode = direction_input ? HBGC_FULL_BWD : HBGC_FULL_FWD;
    end else begin
      mode = direction_input ? HBGC_PWM_BWD : HBGC_PWM_FWD;
    end
    want = decode_gates(mode, pwm_live);
  end

  assign force_off = !sleep_req_n
                   | undervoltage_lock | overvoltage_lock
                   | supervisor_reset | !reset_pin_in
                   | wd_timeout_q;

  // ****************************************************************
  // Watchdog
  // ****************************************************************

  // A kick is a rising edge; any high level held one clock (20 ns) counts,
  // which covers every pulse of the least documented width and more.
  assign kick_edge = watchdog_kick_input & ~kick_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      kick_q <= 1'b0;
    end else begin
      kick_q <= watchdog_kick_input;
    end
  end

  // Timeout counter. Once expired it stops, so the reset pulse fires once
  // and the bridge stays disabled until kicks resume.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_q     <= 32'h0000_0000;
      wd_timeout_q <= 1'b0;
    end else if (kick_edge) begin
      wd_cnt_q     <= 32'h0000_0000;
      wd_timeout_q <= 1'b0;
    end else if (!wd_timeout_q) begin
      if (wd_cnt_q >= WD_CYCLES - 1) begin
        wd_timeout_q <= 1'b1;
      end else begin
        wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Reset pulse: open drain, pulled low for a fixed width on timeout.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_q      <= '0;
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= 1'b1;
    end else begin
      reset_pin_out <= 1'b0;
      if (!wd_timeout_q && !kick_edge && (wd_cnt_q >= WD_CYCLES - 1)) begin
        rst_cnt_q      <= RST_W'(RST_CYC - 1);
        reset_pin_oe_n <= 1'b0;
      end else if (rst_cnt_q != '0) begin
        rst_cnt_q <= rst_cnt_q - RST_W'(1);
      end else begin
        reset_pin_oe_n <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Half-bridge gate drivers with dead time
  // ****************************************************************

  // Each half-bridge turns a gate off at once, restarts its dead timer,
  // and turns a gate on only when the timer is empty and its partner is
  // off. This covers every mode change, not just PWM edges.
  for (genvar i = 0; i < 2; i++) begin : g_half
    logic [DEAD_W-1:0] dead_q;
    logic              drop;
    logic              idle;

    assign drop = (gate_hi_q[i] & ~want[i].hi) | (gate_lo_q[i] & ~want[i].lo);
    assign idle = (dead_q == '0);

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        gate_hi_q[i] <= GATE_RESET;
        gate_lo_q[i] <= GATE_RESET;
        dead_q       <= '0;
      end else if (force_off) begin
        gate_hi_q[i] <= 1'b0;
        gate_lo_q[i] <= 1'b0;
        if (gate_hi_q[i] | gate_lo_q[i]) begin
          dead_q <= DEAD_W'(DEAD_CYCLES);
        end else if (!idle) begin
          dead_q <= dead_q - DEAD_W'(1);
        end
      end else if (drop) begin
        gate_hi_q[i] <= gate_hi_q[i] & want[i].hi;
        gate_lo_q[i] <= gate_lo_q[i] & want[i].lo;
        dead_q       <= DEAD_W'(DEAD_CYCLES);
      end else if (!idle) begin
        dead_q <= dead_q - DEAD_W'(1);
      end else begin
        // Both never wanted together; partner must already be off.
        gate_hi_q[i] <= gate_hi_q[i] | (want[i].hi & ~gate_lo_q[i]);
        gate_lo_q[i] <= gate_lo_q[i] | (want[i].lo & ~gate_hi_q[i]);
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bridge_a_high_gate = gate_hi_q[1];
  assign bridge_a_low_gate  = gate_lo_q[1];
  assign bridge_b_high_gate = gate_hi_q[0];
  assign bridge_b_low_gate  = gate_lo_q[0];

  // Status flags, registered so they line up with the gate outputs.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_active <= 1'b0;
      disable_active <= 1'b0;
    end else begin
      standby_active <= !sleep_req_n;
      disable_active <= undervoltage_lock | overvoltage_lock | supervisor_reset
                      | !reset_pin_in | wd_timeout_q;
    end
  end

endmodule : hbgc_top

// ===== hbgc_pkg.sv
// Purpose: Shared constants and types for the H-bridge gate control block.
// Assumes: A single 50 MHz system clock; all inputs already synchronous to it.
// Notes:   Times are kept in their own units; cycle counts are derived from them.
package hbgc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CLK_NS        = 20;

  // Brake (and full drive) recognition: level must stay put for more than this.
  localparam int unsigned IDLE_US       = 200;
  localparam int unsigned IDLE_CYC      = IDLE_US * 1000 / CLK_NS;

  // Dead time between one gate of a half-bridge going off and the other going on.
  localparam int unsigned DEAD_NS       = 2500;
  localparam int unsigned DEAD_CYC      = (DEAD_NS + CLK_NS - 1) / CLK_NS;

  // Internal PWM frequency.
  localparam int unsigned PWM_HZ        = 25_000;
  localparam int unsigned PWM_CYC       = CLK_HZ / PWM_HZ;

  // Watchdog timeout without timing capacitor, nominal value.
  localparam int unsigned WD_US         = 1000;
  localparam int unsigned WD_CYC        = WD_US * 1000 / CLK_NS;

  // Least retrigger pulse width accepted.
  localparam int unsigned KICK_NS       = 100;
  localparam int unsigned KICK_CYC      = (KICK_NS + CLK_NS - 1) / CLK_NS;

  // Reset output pulse width, nominal value.
  localparam int unsigned RST_US        = 20;
  localparam int unsigned RST_CYC       = RST_US * 1000 / CLK_NS;

  // ****************************************************************
  // Analog speed level thresholds (8-bit code, full scale at 255)
  // ****************************************************************
  localparam logic [7:0]  LEVEL_ZERO_MAX = 8'h3D;
  localparam logic [7:0]  LEVEL_FULL_MIN = 8'hB8;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned DEAD_W        = 8;
  localparam int unsigned PWM_W         = 11;
  localparam int unsigned RST_W         = 10;
  localparam logic        GATE_RESET    = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    HBGC_OFF      = 3'b000,
    HBGC_BRAKE_LO = 3'b001,
    HBGC_BRAKE_HI = 3'b010,
    HBGC_PWM_FWD  = 3'b011,
    HBGC_PWM_BWD  = 3'b100,
    HBGC_FULL_FWD = 3'b101,
    HBGC_FULL_BWD = 3'b110
  } hbgc_mode_e;

  typedef enum logic [1:0] {
    HBGC_LVL_ZERO = 2'b00,
    HBGC_LVL_MID  = 2'b01,
    HBGC_LVL_FULL = 2'b10
  } hbgc_level_e;

  // One half-bridge: high-side and low-side gate command.
  typedef struct packed {
    logic hi;
    logic lo;
  } hbgc_gate_s;

  // Whole bridge: index 1 is half-bridge a, index 0 is half-bridge b.
  typedef hbgc_gate_s [1:0] hbgc_bridge_t;

endpackage : hbgc_pkg

// ===== hbgc_mcu_model.sv
// Purpose: Controller model that retriggers the gate block watchdog.
// Assumes: Kicks change just after the falling clock edge.
// Notes:   Pulses are one cycle wide, below the least accepted width, yet the edge detector takes them.
module hbgc_mcu_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic kick_en,
  output logic      watchdog_kick_input
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Kick generator
  // ****************************************************************
  logic [5:0] gap_q;
  // A kick every 48 cycles stays far inside the timeout; kick_en off starves it.
  always @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 6'h00;
      watchdog_kick_input <= 1'b0;
    end else begin
      gap_q <= (gap_q == 6'h2F) ? 6'h00 : gap_q + 6'h01;
      watchdog_kick_input <= kick_en && (gap_q == 6'h2F);
    end
  end
endmodule : hbgc_mcu_model

// ===== hbgc_chk.sv
// Purpose: Port-level checker of the H-bridge gate control block.
// Assumes: One clock domain; reset active low.
// Notes:   Dead time is judged by how long the partner gate has been off.
module hbgc_chk
  import hbgc_pkg::*;
#(
  parameter int unsigned DEAD_CYCLES = DEAD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sleep_req_n,
  input wire logic undervoltage_lock,
  input wire logic overvoltage_lock,
  input wire logic supervisor_reset,
  input wire logic reset_pin_in,
  input wire logic reset_pin_oe_n,
  input wire logic bridge_a_high_gate,
  input wire logic bridge_a_low_gate,
  input wire logic bridge_b_high_gate,
  input wire logic bridge_b_low_gate,
  input wire logic standby_active,
  input wire logic disable_active
);
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic [3:0]  g;
  logic [7:0]  off_q [4];
  logic [11:0] low_q;
  assign g = {bridge_a_high_gate, bridge_a_low_gate, bridge_b_high_gate, bridge_b_low_gate};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Off time per gate; starts saturated so the first turn-on after reset is legal.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n) off_q[i] <= 8'hFF;
      else if (g[i]) off_q[i] <= 8'h00;
      else if (off_q[i] != 8'hFF) off_q[i] <= off_q[i] + 8'h01;
    end
  end
  // Length of the reset line pulse, saturating.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n || reset_pin_oe_n) low_q <= 12'h000;
    else if (low_q != 12'hFFF) low_q <= low_q + 12'h001;
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_sleep_to_standby: assert property (!sleep_req_n |=> standby_active)
    else $error("standby not entered");
  a_standby_gates_off: assert property (standby_active |-> g == 4'h0)
    else $error("gate on in standby");
  a_cause_to_disable: assert property ((undervoltage_lock || overvoltage_lock
    || supervisor_reset || !reset_pin_in) |=> disable_active) else $error("no disable");
  a_disable_gates_off: assert property (disable_active |-> g == 4'h0)
    else $error("gate on while disabled");
  a_timeout_disables: assert property ($fell(reset_pin_oe_n) |-> ##[1:2] disable_active)
    else $error("timeout left gates enabled");
  a_no_shoot_through: assert property (!(g[3] && g[2]) && !(g[1] && g[0]))
    else $error("both gates of a half-bridge on");
  a_dead_a_high: assert property ($rose(g[3]) |-> off_q[2] > DEAD_CYCLES)
    else $error("dead time short, a high");
  a_dead_a_low: assert property ($rose(g[2]) |-> off_q[3] > DEAD_CYCLES)
    else $error("dead time short, a low");
  a_dead_b_high: assert property ($rose(g[1]) |-> off_q[0] > DEAD_CYCLES)
    else $error("dead time short, b high");
  a_dead_b_low: assert property ($rose(g[0]) |-> off_q[1] > DEAD_CYCLES)
    else $error("dead time short, b low");
  a_pulse_width_ok: assert property ($rose(reset_pin_oe_n) |-> low_q inside {[500:2000]})
    else $error("reset pulse width out of range");
  c_standby: cover property (standby_active);
  c_timeout: cover property ($fell(reset_pin_oe_n));
  c_brake_low: cover property (g == 4'h5);
  c_full_fwd: cover property (g == 4'h9 && !disable_active);
endmodule : hbgc_chk

// ===== hbgc_top_tb.sv
// Purpose: Self-checking bench for the H-bridge gate control block.
// Assumes: Shortened counts; inputs change on the falling clock edge.
// Notes:   Random PWM segments come from an LFSR with a fixed start.
module hbgc_top_tb
  import hbgc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int unsigned DC = 4;
  localparam int unsigned IC = 20;
  localparam int unsigned WC = 200;
  localparam int unsigned PC = 40;
  localparam int unsigned ST = IC + DC + 12;
  logic        sys_clk = 1'b0, rst_n = 1'b0, speed_input = 1'b0, direction_input = 1'b0;
  logic        pwm_freq_cap_pin = 1'b0, sleep_req_n = 1'b1, kick_en = 1'b1;
  logic        watchdog_kick_input, reset_pin_in, reset_pin_out, reset_pin_oe_n;
  logic        bridge_a_high_gate, bridge_a_low_gate, bridge_b_high_gate, bridge_b_low_gate;
  logic        standby_active, disable_active;
  logic [7:0]  speed_level = 8'h00;
  logic [3:0]  cause = 4'h0;
  logic [3:0]  g;
  logic [31:0] lfsr_q = 32'hA6FCCDCD;
  logic [7:0]  lvl_tab [4] = '{8'h00, 8'h3D, 8'hB8, 8'hFF};
  int          failures = 0, num_checks = 0, cyc = 0, hi_cnt, rises, falls, wait_n;
  assign g = {bridge_a_high_gate, bridge_a_low_gate, bridge_b_high_gate, bridge_b_low_gate};
  // Open-drain reset line with pull-up; cause[3] is an outside party pulling it.
  assign reset_pin_in = (reset_pin_oe_n | reset_pin_out) & ~cause[3];
  hbgc_top #(.IDLE_CYCLES(IC), .WD_CYCLES(WC), .DEAD_CYCLES(DC), .PWM_PERIOD(PC)) i_hbgc_top (
    .sys_clk, .rst_n, .speed_input, .speed_level, .direction_input, .pwm_freq_cap_pin,
    .sleep_req_n, .undervoltage_lock(cause[0]), .overvoltage_lock(cause[1]),
    .supervisor_reset(cause[2]), .watchdog_kick_input, .reset_pin_in, .reset_pin_out,
    .reset_pin_oe_n, .bridge_a_high_gate, .bridge_a_low_gate, .bridge_b_high_gate,
    .bridge_b_low_gate, .standby_active, .disable_active);
  hbgc_mcu_model i_hbgc_mcu_model (.sys_clk, .rst_n, .kick_en, .watchdog_kick_input);
  // Clock of 20 ns period.
  always #10 sys_clk = ~sys_clk;
  // Hang guard, far above the few thousand cycles the run needs.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ****************************************************************
  // Tasks and functions
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic draw();
    lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h80200003)};
  endtask : draw
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Counts high cycles and edges of b low gate or of the reset line drive.
  task automatic scan(input int n, input logic use_oe);
    logic prev, cur;
    prev = use_oe ? reset_pin_oe_n : g[0];
    hi_cnt = 0;
    rises = 0;
    falls = 0;
    for (int k = 0; k < n; k++) begin
      tick(1);
      cur = use_oe ? reset_pin_oe_n : g[0];
      hi_cnt += int'(cur);
      rises += int'(cur && !prev);
      falls += int'(!cur && prev);
      prev = cur;
    end
  endtask : scan
  // Settled gates {a_hi, a_lo, b_hi, b_lo}; the PWM low phase rectifies on both highs.
  function automatic logic [3:0] exp_gates(input logic dir, input hbgc_level_e cls,
                                           input logic pwm);
    case (cls)
      HBGC_LVL_ZERO: return dir ? 4'hA : 4'h5;
      HBGC_LVL_FULL: return dir ? 4'h6 : 4'h9;
      default: return pwm ? (dir ? 4'h6 : 4'h9) : 4'hA;
    endcase
  endfunction : exp_gates
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(40);
    for (int i = 0; i < 12; i++) begin
      pwm_freq_cap_pin = (i >= 4);
      speed_input = i[1];
      speed_level = lvl_tab[i[1:0]];
      direction_input = i[2];
      tick(ST);
      check("steady", g, exp_gates(i[2], i[1] ? HBGC_LVL_FULL : HBGC_LVL_ZERO, 1'b0));
    end
    pwm_freq_cap_pin = 1'b0;
    for (int n = 0; n < 60; n++) begin
      draw();
      speed_input = ~speed_input;
      if (lfsr_q[7:5] == 3'h0) direction_input = lfsr_q[8];
      tick(8 + lfsr_q[2:0]);
      check("pwm", g, exp_gates(direction_input, HBGC_LVL_MID, speed_input));
    end
    speed_input = 1'b0;
    tick(10);
    check("pre_brake", g, 4'hA);
    tick(IC + DC);
    check("brake", g, exp_gates(direction_input, HBGC_LVL_ZERO, 1'b0));
    pwm_freq_cap_pin = 1'b1;
    speed_level = 8'h7A;
    direction_input = 1'b0;
    tick(PC);
    scan(10 * PC, 1'b0);
    check("duty", 8'(hi_cnt > 100 && hi_cnt < 260), 8'h01);
    check("period", 8'(rises), 8'h0A);
    pwm_freq_cap_pin = 1'b0;
    speed_input = 1'b1;
    tick(ST);
    sleep_req_n = 1'b0;
    tick(2);
    check("standby", {3'h0, standby_active, g}, 8'h10);
    sleep_req_n = 1'b1;
    for (int c = 0; c < 4; c++) begin
      tick(ST);
      check("drive", {3'h0, disable_active, g}, 8'h09);
      cause = 4'h1 << c;
      tick(2);
      check("disable", {3'h0, disable_active, g}, 8'h10);
      cause = 4'h0;
    end
    tick(ST);
    kick_en = 1'b0;
    for (wait_n = 0; wait_n < 3 * WC && reset_pin_oe_n !== 1'b0; wait_n++) tick(1);
    check("wd_time", 8'(wait_n >= 52 && wait_n <= 2 * WC), 8'h01);
    tick(2);
    check("wd_off", {3'h0, disable_active, g}, 8'h10);
    scan(1500, 1'b1);
    check("wd_once", 8'(falls * 16 + rises), 8'h01);
    check("wd_hold", {7'h00, disable_active}, 8'h01);
    kick_en = 1'b1;
    tick(100);
    check("wd_resume", {3'h0, disable_active, g}, 8'h09);
    rst_n = 1'b0;
    tick(2);
    check("reset", {3'h0, reset_pin_oe_n, g}, 8'h10);
    rst_n = 1'b1;
    tick(5);
    tally_and_finish();
  end
endmodule : hbgc_top_tb
bind hbgc_top hbgc_chk #(.DEAD_CYCLES(DEAD_CYCLES)) i_hbgc_chk (
  .sys_clk, .rst_n, .sleep_req_n, .undervoltage_lock, .overvoltage_lock, .supervisor_reset,
  .reset_pin_in, .reset_pin_oe_n, .bridge_a_high_gate, .bridge_a_low_gate,
  .bridge_b_high_gate, .bridge_b_low_gate, .standby_active, .disable_active);
